/* File: pabo_defines.svh */
// Purpose: constants for the port A/B alternate-function override block
// Assumes: APB register map, 32-bit words, 8-bit registers in low bits
// Notes: included by pabo_pin_cell, pabo_top and the bench
`ifndef PABO_DEFINES_SVH
`define PABO_DEFINES_SVH
`define PABO_OFS_MCU_CONTROL 12'h000
`define PABO_OFS_PORTA_OUT 12'h004
`define PABO_OFS_PORTA_DIR 12'h008
`define PABO_OFS_PORTB_OUT 12'h00c
`define PABO_OFS_PORTB_DIR 12'h010
`define PABO_OFS_PORTA_IN 12'h014
`define PABO_OFS_PORTB_IN 12'h018
`define PABO_OFS_ALT_CTRL 12'h01c
`define PABO_MCU_WMASK 8'h93
`define PABO_MCU_RESET 8'h00
`define PABO_BIT_PULLUP_OFF 4
`define PABO_BIT_SPI_EN 0
`define PABO_BIT_SPI_MASTER 1
`define PABO_BIT_PIN_CHG_EN 2
`define PABO_BIT_PB7_SEL 3
`define PABO_BIT_PROG_MODE 4
`define PABO_BIT_EXT_MEM 7
`define PABO_BYTE_RESET 8'h00
`define PABO_ZERO32 32'h0000_0000
`endif

/* File: pabo_pkg.sv */
// Purpose: shared types for the port override block
// Assumes: constants live in pabo_defines.svh
// Notes: only types here
`default_nettype none
package pabo_pkg;
  typedef logic [7:0] pabo_byte_t;
  typedef enum logic [1:0] {
    PABO_APB_IDLE = 2'b00,
    PABO_APB_SETUP = 2'b01,
    PABO_APB_ACCESS = 2'b10
  } pabo_apb_phase_t;
endpackage
`default_nettype wire

/* File: pabo_pin_cell.sv */
// Purpose: one pin's override combiner and registered pad controls
// Assumes: override signals come from the same clock domain
// Notes: pad input passes a three-stage synchroniser
`default_nettype none
`include "pabo_defines.svh"
module pabo_pin_cell
  import pabo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_direction_bit,
  input wire logic pin_output_bit,
  input wire logic pullup_global_off,
  input wire logic pullup_ovr_en,
  input wire logic pullup_ovr_val,
  input wire logic dir_ovr_en,
  input wire logic dir_ovr_val,
  input wire logic value_ovr_en,
  input wire logic value_ovr_val,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic pin_in
);
  logic next_pullup;
  logic next_oe;
  logic next_out;
  logic [2:0] sync;

  always_comb begin
    next_pullup = pullup_ovr_en ? pullup_ovr_val :
                  (!pin_direction_bit && pin_output_bit && !pullup_global_off);
    next_oe = dir_ovr_en ? dir_ovr_val : pin_direction_bit;
    next_out = (value_ovr_en && next_oe) ? value_ovr_val : pin_output_bit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_pullup <= 1'b0;
      pad_oe <= 1'b0;
      pad_out <= 1'b0;
    end else begin
      pad_pullup <= next_pullup;
      pad_oe <= next_oe;
      pad_out <= next_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 3'h0;
      pin_in <= 1'b0;
    end else begin
      sync <= {sync[1:0], pad_in};
      if (sync[1] == sync[2]) begin
        pin_in <= sync[2];
      end
    end
  end

  a_pullup_global: assert property (@(posedge clk) disable iff (!rst_n)
    (pullup_global_off && !pullup_ovr_en) |=> !pad_pullup) else $error("pull-up on while disabled");
  a_dir_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    dir_ovr_en |=> (pad_oe == $past(dir_ovr_val))) else $error("driver ignores override");
  a_val_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    (value_ovr_en && next_oe) |=> (pad_out == $past(value_ovr_val))) else $error("value override lost");
  a_pull_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    pullup_ovr_en |=> (pad_pullup == $past(pullup_ovr_val))) else $error("pull-up override lost");
endmodule
`default_nettype wire

/* File: pabo_top.sv */
// Purpose: port A/B alternate-function override with APB register file
// Assumes: alternate-function modules share clk; pads resolved by the bench
// Notes: every pad control is registered one cycle after its cause
//
// The APB register port and the address map are this design's own decisions.
`default_nettype none
`include "pabo_defines.svh"
module pabo_top
  import pabo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic addr_phase_active,
  input wire logic ext_wr_phase,
  input wire logic [7:0] ext_addr_low,
  input wire logic [7:0] ext_data_out,
  output logic [7:0] ext_data_in,
  input wire logic timer0_cmp_a_out,
  input wire logic timer0_cmp_a_en,
  input wire logic timer1_cmp_c_out,
  input wire logic timer1_cmp_c_en,
  input wire logic timer1_cmp_b_out,
  input wire logic timer1_cmp_b_en,
  input wire logic timer1_cmp_a_out,
  input wire logic timer1_cmp_a_en,
  input wire logic timer2_cmp_a_out,
  input wire logic timer2_cmp_a_en,
  input wire logic spi_slave_out,
  input wire logic spi_master_out,
  input wire logic spi_sck_out,
  output logic spi_master_in,
  output logic spi_slave_in,
  output logic spi_sck_in,
  output logic spi_ss_in,
  input wire logic prog_serial_out,
  output logic prog_serial_in,
  output logic [7:0] pin_change_source,
  output logic [7:0] ext_mem_addr_shown,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup
);
  pabo_byte_t mcu_control;
  pabo_byte_t pa_port;
  pabo_byte_t pa_dir;
  pabo_byte_t pb_port;
  pabo_byte_t pb_dir;
  pabo_byte_t alt_ctrl;
  pabo_byte_t pa_sync;
  pabo_byte_t pb_sync;
  pabo_byte_t pa_pu_en, pa_pu_val, pa_dd_en, pa_dd_val, pa_pv_en, pa_pv_val;
  pabo_byte_t pb_pu_en, pb_pu_val, pb_dd_en, pb_dd_val, pb_pv_en, pb_pv_val;
  logic pullup_global_off;
  logic ext_mem_enable;
  logic spi_on_master;
  logic wr_strobe;
  logic pb7_from_t1;
  logic [31:0] next_prdata;
  logic prog_mode;
  logic spi_on_slave;
  logic [15:0] cell_dir, cell_port, cell_pu_en, cell_pu_val, cell_dd_en, cell_dd_val;
  logic [15:0] cell_pv_en, cell_pv_val, cell_pad, cell_out, cell_oe, cell_pu, cell_in;

  assign pullup_global_off = mcu_control[`PABO_BIT_PULLUP_OFF];
  assign ext_mem_enable = alt_ctrl[`PABO_BIT_EXT_MEM];
  assign spi_on_master = alt_ctrl[`PABO_BIT_SPI_EN] && alt_ctrl[`PABO_BIT_SPI_MASTER];
  assign spi_on_slave = alt_ctrl[`PABO_BIT_SPI_EN] && !alt_ctrl[`PABO_BIT_SPI_MASTER];
  assign pb7_from_t1 = alt_ctrl[`PABO_BIT_PB7_SEL];
  assign prog_mode = alt_ctrl[`PABO_BIT_PROG_MODE];
  assign wr_strobe = psel && penable && pwrite;

  // ------------------------------------------------------------
  // APB register file
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mcu_control <= `PABO_MCU_RESET;
      pa_port <= `PABO_BYTE_RESET;
      pa_dir <= `PABO_BYTE_RESET;
      pb_port <= `PABO_BYTE_RESET;
      pb_dir <= `PABO_BYTE_RESET;
      alt_ctrl <= `PABO_BYTE_RESET;
    end else if (wr_strobe) begin
      unique case (paddr)
        `PABO_OFS_MCU_CONTROL: mcu_control <= pwdata[7:0] & `PABO_MCU_WMASK;
        `PABO_OFS_PORTA_OUT: pa_port <= pwdata[7:0];
        `PABO_OFS_PORTA_DIR: pa_dir <= pwdata[7:0];
        `PABO_OFS_PORTB_OUT: pb_port <= pwdata[7:0];
        `PABO_OFS_PORTB_DIR: pb_dir <= pwdata[7:0];
        `PABO_OFS_ALT_CTRL: alt_ctrl <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    next_prdata = `PABO_ZERO32;
    unique case (paddr)
      `PABO_OFS_MCU_CONTROL: next_prdata[7:0] = mcu_control;
      `PABO_OFS_PORTA_OUT: next_prdata[7:0] = pa_port;
      `PABO_OFS_PORTA_DIR: next_prdata[7:0] = pa_dir;
      `PABO_OFS_PORTB_OUT: next_prdata[7:0] = pb_port;
      `PABO_OFS_PORTB_DIR: next_prdata[7:0] = pb_dir;
      `PABO_OFS_PORTA_IN: next_prdata[7:0] = pa_sync;
      `PABO_OFS_PORTB_IN: next_prdata[7:0] = pb_sync;
      `PABO_OFS_ALT_CTRL: next_prdata[7:0] = alt_ctrl;
      default: next_prdata = `PABO_ZERO32;
    endcase
  end

  // No wait state: answer in the cycle after setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PABO_ZERO32;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > `PABO_OFS_ALT_CTRL);
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Port A overrides for external memory
  // ------------------------------------------------------------
  always_comb begin
    // external memory takes the whole port
    pa_pu_en = {8{ext_mem_enable}};
    pa_pu_val = {8{!(ext_wr_phase || addr_phase_active) && !pullup_global_off}} & pa_port;
    pa_dd_en = {8{ext_mem_enable}};
    // driver on in address or write phase
    pa_dd_val = {8{ext_wr_phase || addr_phase_active}};
    pa_pv_en = {8{ext_mem_enable}};
    // muxed address and data per bit
    pa_pv_val = (ext_addr_low & {8{addr_phase_active}}) | (ext_data_out & {8{ext_wr_phase}});
  end

  // ------------------------------------------------------------
  // Port B alternate functions
  // ------------------------------------------------------------
  always_comb begin
    pb_pu_en = {4'h0, spi_on_master, {3{spi_on_slave}}};
    pb_pu_val = {4'h0, pb_port[3:0] & {4{!pullup_global_off}}};
    pb_dd_en = {4'h0, spi_on_master, {3{spi_on_slave}}};
    pb_dd_val = 8'h00;
    // timer compare outputs on pins 7..4
    pb_pv_en = {pb7_from_t1 ? timer1_cmp_c_en : timer0_cmp_a_en, timer1_cmp_b_en, timer1_cmp_a_en,
                timer2_cmp_a_en, spi_on_slave || prog_mode, {2{spi_on_master}}, 1'b0};
    // SPI and programming data on pins 3..1
    pb_pv_val = {pb7_from_t1 ? timer1_cmp_c_out : timer0_cmp_a_out, timer1_cmp_b_out, timer1_cmp_a_out,
                 timer2_cmp_a_out, prog_mode ? prog_serial_out : spi_slave_out, spi_master_out,
                 spi_sck_out, 1'b0};
  end

  // Both ports side by side, port A in the low byte
  assign cell_dir = {pb_dir, pa_dir};
  assign cell_port = {pb_port, pa_port};
  assign cell_pu_en = {pb_pu_en, pa_pu_en};
  assign cell_pu_val = {pb_pu_val, pa_pu_val};
  assign cell_dd_en = {pb_dd_en, pa_dd_en};
  assign cell_dd_val = {pb_dd_val, pa_dd_val};
  assign cell_pv_en = {pb_pv_en, pa_pv_en};
  assign cell_pv_val = {pb_pv_val, pa_pv_val};
  assign cell_pad = {pb_in, pa_in};
  assign {pb_out, pa_out} = cell_out;
  assign {pb_oe, pa_oe} = cell_oe;
  assign {pb_pullup, pa_pullup} = cell_pu;
  assign {pb_sync, pa_sync} = cell_in;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      pabo_pin_cell u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .pin_direction_bit(cell_dir[gi]),
        .pin_output_bit(cell_port[gi]),
        .pullup_global_off(pullup_global_off),
        .pullup_ovr_en(cell_pu_en[gi]),
        .pullup_ovr_val(cell_pu_val[gi]),
        .dir_ovr_en(cell_dd_en[gi]),
        .dir_ovr_val(cell_dd_val[gi]),
        .value_ovr_en(cell_pv_en[gi]),
        .value_ovr_val(cell_pv_val[gi]),
        .pad_in(cell_pad[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi]),
        .pad_pullup(cell_pu[gi]),
        .pin_in(cell_in[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Alternate-function inputs, registered
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_data_in <= `PABO_BYTE_RESET;
      pin_change_source <= `PABO_BYTE_RESET;
      ext_mem_addr_shown <= `PABO_BYTE_RESET;
      spi_master_in <= 1'b0;
      spi_slave_in <= 1'b0;
      spi_sck_in <= 1'b0;
      spi_ss_in <= 1'b0;
      prog_serial_in <= 1'b0;
    end else begin
      ext_data_in <= pa_sync;
      pin_change_source <= pb_sync & {8{alt_ctrl[`PABO_BIT_PIN_CHG_EN]}};
      // address shown only in address phase
      ext_mem_addr_shown <= (ext_mem_enable && addr_phase_active) ? ext_addr_low : `PABO_BYTE_RESET;
      spi_master_in <= pb_sync[3];
      spi_slave_in <= pb_sync[2];
      spi_sck_in <= pb_sync[1];
      spi_ss_in <= pb_sync[0];
      prog_serial_in <= pb_sync[2];
    end
  end

  a_mcu_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (mcu_control & ~`PABO_MCU_WMASK) == 8'h00) else $error("reserved bits set");
  a_pa_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_mem_enable && (ext_wr_phase || addr_phase_active)) |=> pa_oe == 8'hff) else $error("port A not driven");
  a_pa_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_mem_enable && addr_phase_active && !ext_wr_phase) |=> pa_out == $past(ext_addr_low)) else $error("bad addr");
  a_pa_pullup: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_mem_enable && pullup_global_off) |=> pa_pullup == 8'h00) else $error("port A pull-up on");
  a_addr_shown: assert property (@(posedge clk) disable iff (!rst_n)
    !addr_phase_active |=> ext_mem_addr_shown == 8'h00) else $error("address shown outside phase");
  a_pb_timer: assert property (@(posedge clk) disable iff (!rst_n)
    (timer1_cmp_b_en && pb_dir[6]) |=> pb_out[6] == $past(timer1_cmp_b_out)) else $error("timer out lost");
  a_apb_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable) |=> pready) else $error("no ready");
  a_pb_sck: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_on_master && pb_dir[1]) |=> pb_out[1] == $past(spi_sck_out)) else $error("sck lost");
  c_ext_write: cover property (@(posedge clk) ext_mem_enable && ext_wr_phase);
  c_ext_addr: cover property (@(posedge clk) ext_mem_enable && addr_phase_active);
  c_spi_master: cover property (@(posedge clk) spi_on_master);
  c_pullup_off_write: cover property (@(posedge clk) wr_strobe && paddr == `PABO_OFS_MCU_CONTROL);
endmodule
`default_nettype wire

/* File: pabo_far_side.sv */
// Purpose: far-side model of the external memory bus and peripheral outputs
// Assumes: bench changes requests just after a rising edge
// Notes: released bus lines show a value that changes every cycle
`default_nettype none
module pabo_far_side (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] req_phase,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [8:0] req_misc,
  input wire logic [4:0] req_en,
  output logic addr_phase_active,
  output logic ext_wr_phase,
  output logic [7:0] ext_addr_low,
  output logic [7:0] ext_data_out,
  output logic [8:0] misc_out,
  output logic [4:0] cmp_en
);
  // ----------------------------------------
  // Bus phases and peripheral values
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_phase_active <= 1'b0;
      ext_wr_phase <= 1'b0;
      ext_addr_low <= 8'h00;
      ext_data_out <= 8'h00;
      misc_out <= 9'h000;
      cmp_en <= 5'h00;
    end else begin
      addr_phase_active <= (req_phase == 2'h1);
      ext_wr_phase <= (req_phase == 2'h2);
      // Not driven: invert so stale values never look valid
      ext_addr_low <= (req_phase == 2'h1) ? req_addr : ~ext_addr_low;
      ext_data_out <= (req_phase == 2'h2) ? req_data : ~ext_data_out;
      misc_out <= req_misc;
      cmp_en <= req_en;
    end
  end
endmodule
`default_nettype wire

/* File: pabo_top_tb_top.sv */
// Purpose: self-checking bench for the port A/B override block
// Assumes: one-cycle APB answer, pad outputs one edge after cause
// Notes: driver queues expectations, a monitor compares them
`default_nettype none
`include "pabo_defines.svh"
module pabo_top_tb_top
  import pabo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] sel; pabo_byte_t mask; logic [32:0] v;} pabo_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] phase = 2'h0;
  pabo_byte_t ra = 8'h00;
  pabo_byte_t rd = 8'h00;
  logic [8:0] misc = 9'h000;
  logic [4:0] en = 5'h00;
  pabo_byte_t pa_in = 8'h00;
  pabo_byte_t pb_in = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, aph, wrp;
  wire [7:0] ea, ed, ext_data_in, pcs, shown, pa_out, pa_oe, pa_pu, pb_out, pb_oe, pb_pu;
  wire [8:0] m_o;
  wire [4:0] c_en, spi_v;
  int n_fail = 0;
  int check_count = 0;
  pabo_note_t rq[$];
  pabo_note_t pq[$];

  always #4 clk = ~clk;

  pabo_far_side far (.clk(clk), .rst_n(rst_n), .req_phase(phase), .req_addr(ra), .req_data(rd), .req_misc(misc),
    .req_en(en), .addr_phase_active(aph), .ext_wr_phase(wrp), .ext_addr_low(ea), .ext_data_out(ed),
    .misc_out(m_o), .cmp_en(c_en));

  pabo_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_phase_active(aph),
    .ext_wr_phase(wrp), .ext_addr_low(ea), .ext_data_out(ed), .ext_data_in(ext_data_in),
    .timer0_cmp_a_out(m_o[4]), .timer0_cmp_a_en(c_en[4]), .timer1_cmp_c_out(m_o[3]), .timer1_cmp_c_en(c_en[3]),
    .timer1_cmp_b_out(m_o[2]), .timer1_cmp_b_en(c_en[2]), .timer1_cmp_a_out(m_o[1]), .timer1_cmp_a_en(c_en[1]),
    .timer2_cmp_a_out(m_o[0]), .timer2_cmp_a_en(c_en[0]), .spi_slave_out(m_o[8]), .spi_master_out(m_o[7]),
    .spi_sck_out(m_o[6]), .spi_master_in(spi_v[4]), .spi_slave_in(spi_v[3]), .spi_sck_in(spi_v[2]),
    .spi_ss_in(spi_v[1]), .prog_serial_out(m_o[5]), .prog_serial_in(spi_v[0]), .pin_change_source(pcs),
    .ext_mem_addr_shown(shown), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pu));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  function automatic pabo_byte_t pick(input logic [3:0] s);
    case (s)
      4'h0: pick = pa_out;
      4'h1: pick = pa_oe;
      4'h2: pick = pa_pu;
      4'h3: pick = shown;
      4'h4: pick = ext_data_in;
      4'h5: pick = pb_out;
      4'h6: pick = pcs;
      4'h7: pick = {3'h0, spi_v};
      4'h8: pick = pb_oe;
      default: pick = pb_pu;
    endcase
  endfunction

  task automatic bad(input logic [32:0] got, input logic [32:0] exp);
    n_fail++;
    $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) bad(got, exp);
  endtask

  task automatic cmp_pin(input pabo_byte_t got, input pabo_note_t n);
    check_count++;
    if ((got & n.mask) !== n.v[7:0]) bad({25'h0, got & n.mask}, n.v);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin : monitor
    pabo_note_t n;
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
      n = rq.pop_front();
      cmp_rd({pslverr, prdata}, n.v);
    end
    if (pq.size() > 0) begin
      n = pq.pop_front();
      cmp_pin(pick(n.sel), n);
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad(33'h0, 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exp_rd(input logic [11:0] a, input logic [32:0] v);
    rq.push_back('{4'h0, 8'hff, v});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic exp_pin(input logic [3:0] s, input pabo_byte_t m, input pabo_byte_t v);
    @(negedge clk);
    pq.push_back('{s, m, {25'h0, v & m}});
    @(posedge clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end

  initial begin
    pabo_byte_t r, m, a, d;
    logic [8:0] v;
    void'($urandom(32'ha10c4619));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    exp_rd(`PABO_OFS_MCU_CONTROL, 33'h0);
    apb(1'b1, `PABO_OFS_MCU_CONTROL, 32'hffff_ffff);
    exp_rd(`PABO_OFS_MCU_CONTROL, 33'h93);
    exp_rd(12'h020, {1'b1, 32'h0});
    r = 8'($urandom) | 8'h81;
    m = 8'($urandom) & 8'h7e;
    apb(1'b1, `PABO_OFS_MCU_CONTROL, 32'h0);
    apb(1'b1, `PABO_OFS_PORTA_OUT, {24'h0, r});
    apb(1'b1, `PABO_OFS_PORTA_DIR, {24'h0, m});
    settle(2);
    exp_pin(4'h2, 8'hff, r & ~m);
    exp_pin(4'h1, 8'hff, m);
    exp_pin(4'h0, m, r);
    apb(1'b1, `PABO_OFS_MCU_CONTROL, 32'h10);
    settle(2);
    exp_pin(4'h2, 8'hff, 8'h00);
    // External memory phases, pull-up disable off then on
    apb(1'b1, `PABO_OFS_ALT_CTRL, 32'h80);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `PABO_OFS_MCU_CONTROL, (k != 0) ? 32'h10 : 32'h0);
      for (int p = 0; p < 3; p++) begin
        a = 8'($urandom);
        d = 8'($urandom);
        phase <= 2'(p);
        ra <= a;
        rd <= d;
        settle(3);
        exp_pin(4'h1, 8'hff, (p != 0) ? 8'hff : 8'h00);
        exp_pin(4'h0, (p != 0) ? 8'hff : 8'h00, (p == 1) ? a : d);
        exp_pin(4'h2, 8'hff, (p == 0 && k == 0) ? r : 8'h00);
        exp_pin(4'h3, 8'hff, (p == 1) ? a : 8'h00);
      end
    end
    apb(1'b1, `PABO_OFS_ALT_CTRL, 32'h0);
    phase <= 2'h1;
    settle(3);
    exp_pin(4'h3, 8'hff, 8'h00);
    exp_pin(4'h1, 8'hff, m);
    a = 8'($urandom);
    phase <= 2'h0;
    pa_in <= a;
    settle(7);
    exp_pin(4'h4, 8'hff, a);
    exp_rd(`PABO_OFS_PORTA_IN, {25'h0, a});
    // Timer compare outputs and programming data out
    apb(1'b1, `PABO_OFS_PORTB_DIR, 32'hf8);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `PABO_OFS_ALT_CTRL, (s != 0) ? 32'h18 : 32'h10);
      v = 9'($urandom);
      misc <= v;
      en <= 5'h1f;
      settle(3);
      exp_pin(4'h5, 8'hf8, {(s != 0) ? v[3] : v[4], v[2:0], v[5], 3'h0});
    end
    en <= 5'h00;
    apb(1'b1, `PABO_OFS_ALT_CTRL, 32'h0);
    apb(1'b1, `PABO_OFS_PORTB_OUT, 32'ha8);
    settle(2);
    exp_pin(4'h5, 8'hf8, 8'ha8);
    exp_pin(4'h8, 8'hff, 8'hf8);
    // SPI master then slave: forced inputs, pull-ups and driven outputs
    apb(1'b1, `PABO_OFS_MCU_CONTROL, 32'h0);
    apb(1'b1, `PABO_OFS_PORTB_DIR, 32'h0f);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `PABO_OFS_ALT_CTRL, (s != 0) ? 32'h1 : 32'h3);
      v = 9'($urandom);
      misc <= v;
      settle(3);
      exp_pin(4'h8, 8'h0f, (s != 0) ? 8'h08 : 8'h07);
      exp_pin(4'h9, 8'h0f, (s != 0) ? 8'h00 : 8'h08);
      exp_pin(4'h5, (s != 0) ? 8'h08 : 8'h06, {4'h0, v[8], v[7], v[6], 1'b0});
    end
    // Port B inputs to SPI, programming and pin-change
    apb(1'b1, `PABO_OFS_PORTB_DIR, 32'h0);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, `PABO_OFS_ALT_CTRL, (c != 0) ? 32'h4 : 32'h0);
      a = 8'($urandom);
      pb_in <= a;
      settle(7);
      exp_pin(4'h6, 8'hff, (c != 0) ? a : 8'h00);
      exp_pin(4'h7, 8'hff, {3'h0, a[3], a[2], a[1], a[0], a[2]});
    end
    settle(2);
    print_verdict();
  end
endmodule
`default_nettype wire
